// [design/pwp_timer_pkg.sv]
// Constants and carrier types for the pulse width and period timer
package pwp_timer_pkg;

  // ********************************************************************
  // Register indices, byte address is four times the index
  // ********************************************************************
  localparam logic [9:0] IDX_CONTROL    = 10'h100; // timer_control_reg
  localparam logic [9:0] IDX_IO_CONTROL = 10'h101; // timer_io_control
  localparam logic [9:0] IDX_MODE       = 10'h102;
  localparam logic [9:0] IDX_PRESCALER  = 10'h103; // prescaler_counter
  localparam logic [9:0] IDX_MAIN       = 10'h104; // main_counter
  localparam logic [9:0] IDX_PIN_SELECT = 10'h105; // pin_select_reg
  localparam logic [9:0] IDX_READOUT    = 10'h106;

  // ********************************************************************
  // Field positions of the control register
  // ********************************************************************
  localparam int CTRL_START_BIT  = 0; // count_start_bit
  localparam int CTRL_STATUS_BIT = 1; // counting status, read only
  localparam int CTRL_STOP_BIT   = 2; // forced_stop_bit, reads zero
  localparam int CTRL_EDGE_BIT   = 3; // active_edge_flag
  localparam int CTRL_UNDF_BIT   = 4; // underflow_flag
  localparam int MODE_PERIOD_BIT = 0;
  localparam int MODE_SRC_LSB    = 1;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] IO_CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET    = 8'hFF;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;

  // ********************************************************************
  // Count source and filter codes, divider lengths
  // ********************************************************************
  localparam logic [2:0] SRC_F1      = 3'h0;
  localparam logic [2:0] SRC_F2      = 3'h1;
  localparam logic [2:0] SRC_F8      = 3'h2;
  localparam logic [2:0] SRC_ONCHIP  = 3'h3;
  localparam logic [2:0] SRC_SUBDIV  = 3'h4;
  localparam logic [2:0] SRC_SUB     = 3'h5;
  localparam logic [1:0] FILT_NONE   = 2'h0;
  localparam logic [1:0] FILT_F1     = 2'h1;
  localparam logic [1:0] FILT_F8     = 2'h2;
  localparam logic [1:0] FILT_F32    = 2'h3;
  localparam int         FILT_SAMPLES = 3;
  localparam logic [4:0] DIV_F2_LAST  = 5'h01;
  localparam logic [4:0] DIV_F8_LAST  = 5'h07;
  localparam logic [4:0] DIV_F32_LAST = 5'h1F;

  // I/O control register layout, bit 7 first
  typedef struct packed {
    logic       event_gate_high;
    logic       event_gate_low;
    logic [1:0] filter_select;           // filter_select_high, _low
    logic       lin_function_select;
    logic       output_pin_enable;
    logic       output_polarity_control;
    logic       edge_level_select;
  } io_ctrl_t;

  // Period measurement sequencing
  typedef enum logic [1:0] {
    MS_WAIT   = 2'b00,
    MS_RELOAD = 2'b01
  } meas_state_t;

endpackage : pwp_timer_pkg

// [design/pwp_timer.sv]
// Pulse width and pulse period measurement timer with Wishbone registers
`timescale 1ns/1ps

// How it works
// - Width mode counts while input equals edge_level_select level.
// - Filter code 00 off, 01 f1, 10 f8, 11 f32 sampling.
// - Filtered level changes only after three equal samples.
// - Period mode measures input period by counting the count source.
// - Source is f1, f2, f8, on-chip osc, subclock/32 or subclock.
// - After edge, latch readout at first underflow, reload at second.
// - Writing one to count start bit with forced stop zero begins counting.
// - Writing zero to start or one to forced stop halts counting.
// - Period mode raises interrupt on counter underflow or reload.
// - Interrupt also raised on the edge ending a measurement.
// - Reading counter registers returns current counts.
// - Writes while stopped load reload register and counter.
// - Writes while counting also load reload register and counter.
// - In period mode edge_level_select picks the delimiting edge.
// - Pin select bits route P1_5 or P1_7 to the measure input.
// - Edge select zero means rising to rising, one falling to falling.
// - Edge and underflow flags clear on written zero, keep on one.
// - Edge flag may set at first prescaler underflow after start.
module pwp_timer (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [11:0] WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  input  wire logic        ONCHIP_OSC_CLOCK_IN,
  input  wire logic        SUBCLOCK_IN,
  input  wire logic        MEAS_P1_5_IN,
  input  wire logic        MEAS_P1_7_IN,
  output logic             WB_ACK_OUT,
  output logic [31:0]      WB_DAT_OUT,
  output logic             TIMER_IRQ_OUT
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  pwp_timer_pkg::io_ctrl_t    io_q;
  pwp_timer_pkg::meas_state_t state_q;
  logic        ack_q, irq_q, counting_q, edge_flag_q, undf_flag_q;
  logic        period_mode_q, osc_prev_q, sub_prev_q;
  logic        filt_q, lvl_prev_q, samp_prev_q;
  logic [31:0] dat_q;
  logic [2:0]  src_sel_q, samples_q;
  logic [1:0]  pin_sel_q;
  logic [7:0]  pre_q, pre_reload_q, main_q, main_reload_q, readout_q;
  logic [4:0]  div_q, sub_div_q;
  logic [7:0]  wdat, rd_data;
  logic        req, wr, wr_ctrl, osc_tick, sub_tick, subdiv_tick;
  logic        src_tick, sample_en, pin_level, level_active, cnt_tick;
  logic        pre_uf, edge_seen, period_edge, width_end;
  logic        reload_evt, underflow_evt;

  // Address match for one register index
  function automatic logic hit(input logic [11:0] adr,
                               input logic [9:0]  idx);
    hit = (adr[11:2] == idx);
  endfunction : hit

  // ********************************************************************
  // Wishbone slave, one wait state, unmapped reads return zero
  // ********************************************************************
  assign req     = WB_CYC_IN & WB_STB_IN & ~ack_q;
  assign wr      = req & WB_WE_IN & WB_SEL_IN[0];
  assign wdat    = WB_DAT_IN[7:0];
  assign wr_ctrl = wr & hit(WB_ADR_IN, pwp_timer_pkg::IDX_CONTROL);

  // Read multiplexer
  always_comb begin
    rd_data = pwp_timer_pkg::ZERO_BYTE;
    if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_CONTROL)) begin
      rd_data[pwp_timer_pkg::CTRL_START_BIT]  = counting_q;
      rd_data[pwp_timer_pkg::CTRL_STATUS_BIT] = counting_q;
      rd_data[pwp_timer_pkg::CTRL_EDGE_BIT]   = edge_flag_q;
      rd_data[pwp_timer_pkg::CTRL_UNDF_BIT]   = undf_flag_q;
    end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_IO_CONTROL)) begin
      rd_data = io_q;
    end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_MODE)) begin
      rd_data = {4'h0, src_sel_q, period_mode_q};
    end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_PRESCALER)) begin
      rd_data = pre_q;
    end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_MAIN)) begin
      rd_data = main_q;
    end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_PIN_SELECT)) begin
      rd_data = {6'h00, pin_sel_q};
    end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_READOUT)) begin
      rd_data = readout_q;
    end
  end

  // Acknowledge and read data
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      io_q          <= pwp_timer_pkg::IO_CONTROL_RESET;
      period_mode_q <= 1'b0;
      src_sel_q     <= pwp_timer_pkg::SRC_F1;
      pin_sel_q     <= 2'h0;
    end else if (wr) begin
      if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_IO_CONTROL)) begin
        io_q <= wdat;
      end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_MODE)) begin
        period_mode_q <= wdat[pwp_timer_pkg::MODE_PERIOD_BIT];
        src_sel_q     <= wdat[pwp_timer_pkg::MODE_SRC_LSB +: 3];
      end else if (hit(WB_ADR_IN, pwp_timer_pkg::IDX_PIN_SELECT)) begin
        pin_sel_q <= wdat[1:0];
      end
    end
  end

  // ********************************************************************
  // Count sources and filter sampling clocks
  // ********************************************************************
  assign osc_tick    = ONCHIP_OSC_CLOCK_IN & ~osc_prev_q;
  assign sub_tick    = SUBCLOCK_IN & ~sub_prev_q;
  assign subdiv_tick = sub_tick & (sub_div_q == pwp_timer_pkg::DIV_F32_LAST);

  // Free dividers of the system clock and of the subclock
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      div_q      <= 5'h00;
      sub_div_q  <= 5'h00;
      osc_prev_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else begin
      div_q      <= div_q + 5'h01;
      sub_div_q  <= sub_tick ? sub_div_q + 5'h01 : sub_div_q;
      osc_prev_q <= ONCHIP_OSC_CLOCK_IN;
      sub_prev_q <= SUBCLOCK_IN;
    end
  end

  // Count source select
  always_comb begin
    case (src_sel_q)
      pwp_timer_pkg::SRC_F1:     src_tick = 1'b1;
      pwp_timer_pkg::SRC_F2:
        src_tick = (div_q[0] == pwp_timer_pkg::DIV_F2_LAST[0]);
      pwp_timer_pkg::SRC_F8:
        src_tick = (div_q[2:0] == pwp_timer_pkg::DIV_F8_LAST[2:0]);
      pwp_timer_pkg::SRC_ONCHIP: src_tick = osc_tick;
      pwp_timer_pkg::SRC_SUBDIV: src_tick = subdiv_tick;
      pwp_timer_pkg::SRC_SUB:    src_tick = sub_tick;
      default:                   src_tick = 1'b0;
    endcase
  end

  // Filter sampling rate
  always_comb begin
    case (io_q.filter_select)
      pwp_timer_pkg::FILT_F1:  sample_en = 1'b1;
      pwp_timer_pkg::FILT_F8:
        sample_en = (div_q[2:0] == pwp_timer_pkg::DIV_F8_LAST[2:0]);
      pwp_timer_pkg::FILT_F32:
        sample_en = (div_q == pwp_timer_pkg::DIV_F32_LAST);
      default:                 sample_en = 1'b0;
    endcase
  end

  // ********************************************************************
  // Input routing and digital filter
  // ********************************************************************
  assign pin_level = (pin_sel_q[0] & MEAS_P1_5_IN) |
                     (pin_sel_q[1] & MEAS_P1_7_IN);

  // Three sample shift register, level accepted when all agree
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      samples_q <= 3'h0;
      filt_q    <= 1'b0;
    end else if (io_q.filter_select == pwp_timer_pkg::FILT_NONE) begin
      samples_q <= {pin_level, pin_level, pin_level};
      filt_q    <= pin_level;
    end else begin
      if (sample_en) begin
        samples_q <= {samples_q[1:0], pin_level};
      end
      if (&samples_q || ~|samples_q) begin
        filt_q <= samples_q[0];
      end
    end
  end

  // ********************************************************************
  // Measurement events
  // ********************************************************************
  assign level_active = (filt_q == io_q.edge_level_select);
  assign width_end    = counting_q & ~period_mode_q & lvl_prev_q &
                        ~level_active;
  // Edge select 0 rising, 1 falling
  assign edge_seen    = io_q.edge_level_select ?
                        (samp_prev_q & ~filt_q) :
                        (~samp_prev_q & filt_q);
  assign cnt_tick     = counting_q & src_tick &
                        (period_mode_q | level_active);
  assign pre_uf       = cnt_tick & (pre_q == pwp_timer_pkg::ZERO_BYTE);
  // Input sampled once per prescaler period, so narrower pulses are lost
  assign period_edge  = pre_uf & period_mode_q &
                        (state_q == pwp_timer_pkg::MS_WAIT) &
                        edge_seen;
  assign reload_evt   = pre_uf & period_mode_q &
                        (state_q == pwp_timer_pkg::MS_RELOAD);
  assign underflow_evt = pre_uf & ~reload_evt &
                         (main_q == pwp_timer_pkg::ZERO_BYTE);

  // Level history for edge detection
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      lvl_prev_q  <= 1'b0;
      samp_prev_q <= 1'b0;
    end else begin
      lvl_prev_q <= counting_q & level_active;
      if (wr_ctrl & wdat[pwp_timer_pkg::CTRL_START_BIT] & ~counting_q) begin
        samp_prev_q <= 1'b0;
      end else if (pre_uf) begin
        samp_prev_q <= filt_q;
      end
    end
  end

  // Period sequencing: latch on edge underflow, reload on the next
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_q   <= pwp_timer_pkg::MS_WAIT;
      readout_q <= pwp_timer_pkg::ZERO_BYTE;
    end else begin
      if (!counting_q || !period_mode_q) begin
        state_q <= pwp_timer_pkg::MS_WAIT;
      end else if (pre_uf) begin
        case (state_q)
          pwp_timer_pkg::MS_WAIT:
            state_q <= period_edge ? pwp_timer_pkg::MS_RELOAD
                                   : pwp_timer_pkg::MS_WAIT;
          default:
            state_q <= pwp_timer_pkg::MS_WAIT;
        endcase
      end
      if (period_edge) begin
        readout_q <= main_q;
      end
    end
  end

  // ********************************************************************
  // Start, stop and flags
  // ********************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      counting_q <= 1'b0;
    end else if (wr_ctrl) begin
      counting_q <= wdat[pwp_timer_pkg::CTRL_START_BIT] &
                    ~wdat[pwp_timer_pkg::CTRL_STOP_BIT];
    end
  end

  // Sticky flags, a hardware set wins over a written zero
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      edge_flag_q <= 1'b0;
      undf_flag_q <= 1'b0;
    end else begin
      edge_flag_q <= (period_edge | width_end) |
                     (edge_flag_q & ~(wr_ctrl &
                      ~wdat[pwp_timer_pkg::CTRL_EDGE_BIT]));
      undf_flag_q <= underflow_evt |
                     (undf_flag_q & ~(wr_ctrl &
                      ~wdat[pwp_timer_pkg::CTRL_UNDF_BIT]));
    end
  end

  // Interrupt request pulse
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= underflow_evt | reload_evt |
               period_edge | width_end;
    end
  end

  // ********************************************************************
  // Prescaler and main counter
  // ********************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pre_q        <= pwp_timer_pkg::COUNTER_RESET;
      pre_reload_q <= pwp_timer_pkg::COUNTER_RESET;
    end else if (wr && hit(WB_ADR_IN, pwp_timer_pkg::IDX_PRESCALER)) begin
      pre_q        <= wdat;
      pre_reload_q <= wdat;
    end else if (cnt_tick) begin
      pre_q <= pre_uf ? pre_reload_q : pre_q - 8'h01;
    end
  end

  // Main counter steps on prescaler underflow
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      main_q        <= pwp_timer_pkg::COUNTER_RESET;
      main_reload_q <= pwp_timer_pkg::COUNTER_RESET;
    end else if (wr && hit(WB_ADR_IN, pwp_timer_pkg::IDX_MAIN)) begin
      main_q        <= wdat;
      main_reload_q <= wdat;
    end else if (reload_evt || underflow_evt) begin
      main_q <= main_reload_q;
    end else if (pre_uf) begin
      main_q <= main_q - 8'h01;
    end
  end

  assign WB_ACK_OUT    = ack_q;
  assign WB_DAT_OUT    = dat_q;
  assign TIMER_IRQ_OUT = irq_q;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  ack_single_a: assert property (ack_q |=> !ack_q)
    else $error("ack held two cycles");
  start_write_a: assert property (
    wr_ctrl && wdat[0] && !wdat[2] |=> counting_q)
    else $error("start write did not start counting");
  forced_stop_a: assert property (
    wr_ctrl && wdat[2] |=> !counting_q ##1 !irq_q || counting_q)
    else $error("forced stop did not stop counting");
  flag_clear_a: assert property (
    wr_ctrl && !wdat[3] && !period_edge && !width_end |=> !edge_flag_q)
    else $error("edge flag not cleared by zero write");
  underflow_reload_a: assert property (
    underflow_evt && !wr |=> main_q == $past(main_reload_q) && irq_q
                             && undf_flag_q)
    else $error("underflow did not reload and request");
  period_seq_a: assert property (
    period_edge && !wr |=> readout_q == $past(main_q) &&
                           state_q == pwp_timer_pkg::MS_RELOAD)
    else $error("edge underflow did not latch readout");
  edge_irq_a: assert property (
    width_end |=> irq_q && edge_flag_q)
    else $error("end of width gave no request");
  filter_hold_a: assert property (
    io_q.filter_select != pwp_timer_pkg::FILT_NONE &&
    $stable(io_q.filter_select) && $changed(filt_q) |->
    $past(samples_q) == {3{filt_q}})
    else $error("filter accepted without three samples");
  prescale_step_a: assert property (
    cnt_tick && pre_q != 8'h00 && !wr |=> pre_q == $past(pre_q) - 8'h01)
    else $error("prescaler did not step down");

  period_edge_c: cover property (period_edge ##[1:300] reload_evt);
  underflow_c:   cover property (underflow_evt);
  width_end_c:   cover property (width_end);

endmodule : pwp_timer

// [tb/pulse_source.sv]
// Behavioural external pulse source for one measure pin
`timescale 1ns/1ps
module pulse_source (
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic [7:0] half_in,
  output logic            pin_out
);
  logic [7:0] cnt_q;
  // Square wave, each half longer than a prescaler period
  always_ff @(posedge clk_in) begin
    if (!run_in) begin
      cnt_q   <= 8'h00;
      pin_out <= 1'b0;
    end else if (cnt_q == half_in - 8'h01) begin
      cnt_q   <= 8'h00;
      pin_out <= ~pin_out;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : pulse_source

// [tb/pwp_timer_tb.sv]
// Self-checking testbench for the pulse width and period timer
`timescale 1ns/1ps
module pwp_timer_tb;
  logic        clk, rst, cyc, stb, we_r, osc, sub, run5, run7;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [7:0]  div_q, rd, a, b;
  logic        ack, irq, p15, p17;
  int          n_errors, tests_run, irq_cnt;

  pwp_timer DUT (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we_r), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .ONCHIP_OSC_CLOCK_IN(osc), .SUBCLOCK_IN(sub),
    .MEAS_P1_5_IN(p15), .MEAS_P1_7_IN(p17), .WB_ACK_OUT(ack),
    .WB_DAT_OUT(rdat), .TIMER_IRQ_OUT(irq));
  pulse_source src5 (.clk_in(clk), .run_in(run5), .half_in(8'h14),
    .pin_out(p15));
  pulse_source src7 (.clk_in(clk), .run_in(run7), .half_in(8'h14),
    .pin_out(p17));

  // ****************************************************************
  // Clock, slow sources, irq tally
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    div_q <= div_q + 8'h01;
    osc   <= div_q[1];
    sub   <= div_q[3];
    if (irq === 1'b1) irq_cnt++;
  end

  // ****************************************************************
  // Bus, compare and closing tasks
  // ****************************************************************
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we_r <= w;
    sel  <= 4'hF;
    adr  <= {i, 2'b00};
    wdat <= {24'h000000, d};
    // Wait for the answer; a hang is left to the watchdog
    do @(posedge clk);
    while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    wb(0, 10'h101, 8'h00); chk("ioctl_rst", 8'h00, rd);
    wb(0, 10'h1FF, 8'h00); chk("unmapped", 8'h00, rd);
    for (int f = 0; f < 4; f++) begin
      // Lin and event gate bits stay zero
      wb(1, 10'h101, {2'b00, f[1:0], 4'h7});
      wb(0, 10'h101, 8'h00); chk("ioctl", {2'b00, f[1:0], 4'h7}, rd);
    end
    wb(1, 10'h101, 8'h00);
    wb(1, 10'h103, 8'h5A);
    wb(0, 10'h103, 8'h00); chk("pre_wr", 8'h5A, rd);
  endtask : t_regs

  task automatic t_sources();
    for (int s = 0; s < 6; s++) begin
      wb(1, 10'h103, 8'h00);
      wb(1, 10'h104, 8'hFF);
      wb(1, 10'h102, {4'h0, s[2:0], 1'b1});
      irq_cnt = 0;
      wb(1, 10'h100, 8'h01);
      repeat (600) @(posedge clk);
      // Odd sources stop by the forced stop bit with start still set
      wb(1, 10'h100, s[0] ? 8'h1D : 8'h18);
      wb(0, 10'h104, 8'h00);
      a = rd;
      repeat (20) @(posedge clk);
      wb(0, 10'h104, 8'h00); chk("stopped", a, rd);
      chk("moved", 8'h01, {7'h00, a !== 8'hFF});
      wb(0, 10'h100, 8'h00); chk("undf", s < 2 ? 8'h10 : 8'h00, rd & 8'h10);
      chk("undf_irq", s < 2 ? 8'h01 : 8'h00, {7'h00, irq_cnt > 0});
      wb(1, 10'h100, 8'h00);
      wb(0, 10'h100, 8'h00); chk("clr", 8'h00, rd & 8'h18);
    end
  endtask : t_sources

  task automatic t_period();
    for (int k = 0; k < 2; k++) begin
      wb(1, 10'h105, k ? 8'h02 : 8'h01);
      // Second pass runs the input through the f1 filter
      wb(1, 10'h101, {3'h0, k[0], 3'h0, k[0]});
      wb(1, 10'h102, 8'h01);
      wb(1, 10'h103, 8'h00);
      wb(1, 10'h104, 8'hFF);
      irq_cnt = 0;
      run5 <= (k == 0);
      run7 <= (k == 1);
      wb(1, 10'h100, 8'h01);
      repeat (200) @(posedge clk);
      wb(0, 10'h106, 8'h00); chk("readout", 8'hD9, rd);
      wb(0, 10'h100, 8'h00); chk("edgef", 8'h08, rd & 8'h08);
      chk("irqs", 8'h01, {7'h00, irq_cnt >= 6});
      wb(1, 10'h100, 8'h00);
      run5 <= 1'b0;
      run7 <= 1'b0;
    end
  endtask : t_period

  // Width mode: idle low pin with high measured, then pulsing pin with low measured
  task automatic t_width();
    for (int k = 0; k < 2; k++) begin
      wb(1, 10'h105, 8'h01);
      wb(1, 10'h101, {7'h00, ~k[0]});
      wb(1, 10'h102, 8'h00);
      wb(1, 10'h103, 8'h00);
      wb(1, 10'h104, 8'hFF);
      run5 <= (k == 1);
      wb(1, 10'h100, 8'h01);
      repeat (200) @(posedge clk);
      wb(1, 10'h100, 8'h18);
      wb(0, 10'h104, 8'h00);
      a = rd;
      chk("width_cnt", k ? 8'h01 : 8'h00, {7'h00, a !== 8'hFF});
      wb(0, 10'h100, 8'h00);
      chk("width_end", k ? 8'h08 : 8'h00, rd & 8'h08);
      wb(1, 10'h100, 8'h00);
      run5 <= 1'b0;
    end
  endtask : t_width

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    {rst, cyc, stb, we_r, run5, run7} = 6'b100000;
    adr = 12'h000;
    sel = 4'h0;
    wdat = 32'h00000000;
    {div_q, osc, sub} = 10'h000;
    {n_errors, tests_run, irq_cnt} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_sources();
    t_period();
    t_width();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : pwp_timer_tb
